// ===== core/sem_host_pkg.sv
// constants for the semaphore port host controller
package sem_host_pkg;
   localparam int FLAG_COUNT = 8;
   localparam int IDX_W = 3;
   localparam int DATA_W = 18;
   localparam int ADDR_W = 19;
   // pin timing: least cycle figures of the far device, in ns
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETUP_NS = 20;
   localparam int STROBE_NS = 30;
   localparam int RECOVER_NS = 20;
   localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // command codes on the user port
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_CLAIM = 2'h1;
   localparam logic [1:0] CMD_RELEASE = 2'h2;
   localparam logic [1:0] CMD_INIT = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b010,
      ST_RECOVER = 3'b011,
      ST_DONE = 3'b100
   } state_t;
endpackage

// ===== core/sem_host.sv
// host controller driving one port of a dual-port semaphore flag space
// ------------------------------------------------------------
// Functional notes
// R1: eight flags selected by flag space select low
// R2: only three low address lines pick flag
// R3: write value only on lsb data line
// R4: zero to free flag: owner reads zero
// R5: only the owning side changes the flag
// R6: owner writing one frees flag unless pending
// R7: losing zero waits in request latch
// R8: read returns flag on every data bit
// R9: read needs select, byte enable, output enable
// R10: read value held for whole read
// R11: claim is write zero then read back
// R12: failed claim: keep reading or write one
// R13: first zero latch owns the flag
// R14: ownership passes on release if pending
// R15: simultaneous requests give one winner
// R16: software writes one everywhere at start
// R17: flags active low: zero claims, one releases
// R18: flags never gate array accesses
// R19: flags may power up undefined
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module sem_host (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   // user command port
   input wire logic CMD_VALID,
   input wire logic [1:0] CMD_OP,
   input wire logic [2:0] CMD_FLAG,
   output logic CMD_READY,
   output logic RSP_VALID,
   output logic RSP_GRANTED,
   output logic RSP_FLAG_HIGH,
   // pins toward the dual-port device
   output logic FLAG_SPACE_SELECT_N,
   output logic CHIP_ENABLE_LOW_ACTIVE_N,
   output logic CHIP_ENABLE_HIGH_ACTIVE,
   output logic WRITE_N,
   output logic OUTPUT_ENABLE_N,
   output logic [1:0] BYTE_LANE_ENABLE_N,
   output logic [sem_host_pkg::ADDR_W-1:0] ADDR,
   output logic [sem_host_pkg::DATA_W-1:0] DATA_OUT,
   output logic DATA_OE,
   input wire logic [sem_host_pkg::DATA_W-1:0] DATA_IN
);
   // ------------------------------------------------------------
   // pin input synchroniser
   // ------------------------------------------------------------
   logic [sem_host_pkg::DATA_W-1:0] din_s1_r, din_s2_r;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         din_s1_r <= '0;
         din_s2_r <= '0;
      end else if (CE) begin
         din_s1_r <= DATA_IN;
         din_s2_r <= din_s1_r;
      end
   end

   // ------------------------------------------------------------
   // access sequencer
   // ------------------------------------------------------------
   sem_host_pkg::state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [1:0] op_r, op_nxt;
   logic [2:0] flag_r, flag_nxt;
   logic write_phase_r, write_phase_nxt;
   logic [2:0] init_left_r, init_left_nxt;
   logic sel_n_r, sel_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt, doe_r, doe_nxt;
   logic wval_r, wval_nxt;
   logic rsp_v_r, rsp_v_nxt, rsp_g_r, rsp_g_nxt, rsp_h_r, rsp_h_nxt;

   // all-ones reads mean one, all-zero reads zero; mixed is treated as one
   function automatic logic flag_is_zero(input logic [sem_host_pkg::DATA_W-1:0] d);
      flag_is_zero = (d == '0); // [R8]
   endfunction

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      op_nxt = op_r;
      flag_nxt = flag_r;
      write_phase_nxt = write_phase_r;
      init_left_nxt = init_left_r;
      sel_n_nxt = sel_n_r;
      we_n_nxt = we_n_r;
      oe_n_nxt = oe_n_r;
      doe_nxt = doe_r;
      wval_nxt = wval_r;
      rsp_v_nxt = 1'b0;
      rsp_g_nxt = rsp_g_r;
      rsp_h_nxt = rsp_h_r;
      case (state_r)
         sem_host_pkg::ST_IDLE: begin
            if (CMD_VALID) begin
               op_nxt = CMD_OP;
               flag_nxt = CMD_FLAG; // [R2]
               init_left_nxt = 3'h7;
               // claim writes first, then reads back; never read-then-write [R11]
               write_phase_nxt = (CMD_OP != sem_host_pkg::CMD_READ);
               // release and init write one; a failed claim is withdrawn this way [R12] [R17]
               wval_nxt = (CMD_OP != sem_host_pkg::CMD_CLAIM);
               state_nxt = sem_host_pkg::ST_SETUP;
               cnt_nxt = sem_host_pkg::SETUP_CYC;
               sel_n_nxt = 1'b0; // [R1]
               we_n_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               doe_nxt = (CMD_OP != sem_host_pkg::CMD_READ);
            end
         end
         sem_host_pkg::ST_SETUP: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               state_nxt = sem_host_pkg::ST_STROBE;
               cnt_nxt = sem_host_pkg::STROBE_CYC;
               we_n_nxt = !write_phase_r;
               // select, byte enables and output enable all active to read [R9]
               oe_n_nxt = write_phase_r;
            end
         end
         sem_host_pkg::ST_STROBE: begin
            cnt_nxt = cnt_r - 4'h1;
            if (cnt_r == 4'h1) begin
               // device holds its captured value while oe stays low [R10]
               if (!write_phase_r) begin
                  rsp_h_nxt = !flag_is_zero(din_s2_r);
                  rsp_g_nxt = flag_is_zero(din_s2_r); // [R4]
               end
               we_n_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               state_nxt = sem_host_pkg::ST_RECOVER;
               cnt_nxt = sem_host_pkg::RECOVER_CYC;
            end
         end
         sem_host_pkg::ST_RECOVER: begin
            cnt_nxt = cnt_r - 4'h1;
            doe_nxt = 1'b0;
            // select lifts a cycle after the strobes, so a write closes on its strobe edge
            if (cnt_r == sem_host_pkg::RECOVER_CYC) begin
               sel_n_nxt = 1'b1;
            end
            if (cnt_r == 4'h1) begin
               state_nxt = sem_host_pkg::ST_DONE;
               if (op_r == sem_host_pkg::CMD_CLAIM && write_phase_r) begin
                  write_phase_nxt = 1'b0; // verify the claim by reading back [R11]
                  state_nxt = sem_host_pkg::ST_SETUP;
                  cnt_nxt = sem_host_pkg::SETUP_CYC;
                  sel_n_nxt = 1'b0;
               end else if (op_r == sem_host_pkg::CMD_INIT && init_left_r != 3'h0) begin
                  // init writes one to all eight flags [R16] [R19]
                  init_left_nxt = init_left_r - 3'h1;
                  flag_nxt = flag_r + 3'h1;
                  state_nxt = sem_host_pkg::ST_SETUP;
                  cnt_nxt = sem_host_pkg::SETUP_CYC;
                  sel_n_nxt = 1'b0;
                  doe_nxt = 1'b1;
               end
            end
         end
         sem_host_pkg::ST_DONE: begin
            rsp_v_nxt = 1'b1;
            if (op_r != sem_host_pkg::CMD_READ && op_r != sem_host_pkg::CMD_CLAIM) begin
               rsp_g_nxt = 1'b0;
               rsp_h_nxt = 1'b1;
            end
            state_nxt = sem_host_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = sem_host_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r <= sem_host_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         op_r <= 2'h0;
         flag_r <= 3'h0;
         write_phase_r <= 1'b0;
         init_left_r <= 3'h0;
         sel_n_r <= 1'b1;
         we_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         doe_r <= 1'b0;
         wval_r <= 1'b1;
         rsp_v_r <= 1'b0;
         rsp_g_r <= 1'b0;
         rsp_h_r <= 1'b1;
      end else if (CE) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         op_r <= op_nxt;
         flag_r <= flag_nxt;
         write_phase_r <= write_phase_nxt;
         init_left_r <= init_left_nxt;
         sel_n_r <= sel_n_nxt;
         we_n_r <= we_n_nxt;
         oe_n_r <= oe_n_nxt;
         doe_r <= doe_nxt;
         wval_r <= wval_nxt;
         rsp_v_r <= rsp_v_nxt;
         rsp_g_r <= rsp_g_nxt;
         rsp_h_r <= rsp_h_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs, all from flops except the tied-off array chip enables
   // ------------------------------------------------------------
   // ready is registered: a flop loaded from the idle decode of state_nxt
   logic ready_r;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ready_r <= 1'b0;
      end else if (CE) begin
         ready_r <= (state_nxt == sem_host_pkg::ST_IDLE) && !(state_r == sem_host_pkg::ST_IDLE && CMD_VALID);
      end
   end

   assign CMD_READY = ready_r;
   assign RSP_VALID = rsp_v_r;
   assign RSP_GRANTED = rsp_g_r;
   assign RSP_FLAG_HIGH = rsp_h_r;
   assign FLAG_SPACE_SELECT_N = sel_n_r;
   // array chip enables stay off; flags never touch the array [R18]
   assign CHIP_ENABLE_LOW_ACTIVE_N = 1'b1;
   assign CHIP_ENABLE_HIGH_ACTIVE = 1'b0;
   assign WRITE_N = we_n_r;
   assign OUTPUT_ENABLE_N = oe_n_r;
   assign BYTE_LANE_ENABLE_N = {sel_n_r, sel_n_r};
   assign ADDR = {{(sem_host_pkg::ADDR_W-3){1'b0}}, flag_r};
   // only bit 0 matters on a write; others copy it for clean lines [R3]
   assign DATA_OUT = {sem_host_pkg::DATA_W{wval_r}};
   assign DATA_OE = doe_r;
endmodule
`default_nettype wire

// ===== verification/sem_flag_model.sv
// behavioural semaphore flag space; the bench works the far port by task
`timescale 1ns/1ns
`default_nettype none
module sem_flag_model (
   input wire logic sel_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [1:0] be_n,
   input wire logic [2:0] idx,
   input wire logic wbit,
   output logic [17:0] dq
);
   // owner per flag: 0 free, 1 near port, 2 far port
   logic [7:0] req_a = 8'hA5; // arbitrary power-up latches
   logic [7:0] req_b = 8'h3C;
   logic [1:0] own [8];
   logic q_r = 1'b1;
   logic acc;
   // first latch at zero owns; a release hands over to a pending request
   function automatic void settle(input logic [2:0] i);
      if (own[i] == 2'h1 && req_a[i]) own[i] = req_b[i] ? 2'h0 : 2'h2;
      if (own[i] == 2'h2 && req_b[i]) own[i] = req_a[i] ? 2'h0 : 2'h1;
      if (own[i] == 2'h0) own[i] = !req_a[i] ? 2'h1 : (!req_b[i] ? 2'h2 : 2'h0);
   endfunction
   initial for (int i = 0; i < 8; i++) begin
      own[i] = 2'h0;
      settle(3'(i));
   end
   assign acc = !sel_n && be_n != 2'h3;
   always @(posedge we_n) if (acc) begin
      req_a[idx] = wbit;
      settle(idx);
   end
   always @(negedge oe_n) if (acc) q_r = own[idx] != 2'h1;
   // released bus shows the inverse so a stale value never reads as valid
   assign dq = (acc && !oe_n) ? {18{q_r}} : ~{18{q_r}};
   task automatic far_write(input logic [2:0] i, input logic v);
      req_b[i] = v;
      settle(i);
   endtask
   function automatic logic far_read(input logic [2:0] i);
      return own[i] != 2'h2;
   endfunction
endmodule
`default_nettype wire

// ===== verification/sem_host_monitor.sv
// pin checker for the semaphore host controller
`timescale 1ns/1ns
`default_nettype none
module sem_host_monitor (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CMD_VALID,
   input wire logic CMD_READY,
   input wire logic RSP_VALID,
   input wire logic FLAG_SPACE_SELECT_N,
   input wire logic CHIP_ENABLE_LOW_ACTIVE_N,
   input wire logic CHIP_ENABLE_HIGH_ACTIVE,
   input wire logic WRITE_N,
   input wire logic OUTPUT_ENABLE_N,
   input wire logic [1:0] BYTE_LANE_ENABLE_N,
   input wire logic [18:0] ADDR,
   input wire logic [17:0] DATA_OUT,
   input wire logic DATA_OE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   a_addr_low_only: assert property (!FLAG_SPACE_SELECT_N |-> ADDR[18:3] == 16'h0)
      else $error("upper address bits set in flag access");
   a_data_replica: assert property (DATA_OE |-> DATA_OUT == {18{DATA_OUT[0]}})
      else $error("write data bits differ");
   a_read_select: assert property (!OUTPUT_ENABLE_N |-> !FLAG_SPACE_SELECT_N && BYTE_LANE_ENABLE_N == 2'h0)
      else $error("read without select or byte enables");
   a_write_select: assert property (!WRITE_N |-> !FLAG_SPACE_SELECT_N && DATA_OE)
      else $error("write strobe without select or data");
   a_read_quiet: assert property (!OUTPUT_ENABLE_N |-> WRITE_N && !DATA_OE)
      else $error("host drives data during read");
   a_read_hold: assert property ($fell(OUTPUT_ENABLE_N) |=> !OUTPUT_ENABLE_N [*2])
      else $error("read strobe too short");
   a_write_close: assert property ($rose(WRITE_N) |-> !FLAG_SPACE_SELECT_N)
      else $error("select lifted with the write strobe");
   a_array_off: assert property (CHIP_ENABLE_LOW_ACTIVE_N && !CHIP_ENABLE_HIGH_ACTIVE)
      else $error("array chip enables active");
   a_one_pulse: assert property (RSP_VALID |=> !RSP_VALID)
      else $error("response longer than one cycle");
   a_take_busy: assert property (CMD_VALID && CMD_READY |=> !CMD_READY ##[1:150] RSP_VALID)
      else $error("command not answered in time");
   c_claim: cover property (!WRITE_N && !DATA_OUT[0]);
   c_release: cover property (!WRITE_N && DATA_OUT[0]);
   c_read: cover property (!OUTPUT_ENABLE_N);
endmodule
`default_nettype wire

// ===== verification/sem_host_test.sv
// self-checking bench for the semaphore host controller
`timescale 1ns/1ns
`default_nettype none
module sem_host_test;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic CE = 1'b1;
   logic CMD_VALID = 1'b0;
   logic [1:0] CMD_OP = 2'h0;
   logic [2:0] CMD_FLAG = 3'h0;
   logic CMD_READY, RSP_VALID, RSP_GRANTED, RSP_FLAG_HIGH, FLAG_SPACE_SELECT_N, WRITE_N;
   logic OUTPUT_ENABLE_N, DATA_OE;
   logic [1:0] BYTE_LANE_ENABLE_N;
   logic [18:0] ADDR;
   logic [17:0] DATA_OUT, DATA_IN, dq;
   logic [2:0] q [$];
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000141B;
   assign DATA_IN = DATA_OE ? DATA_OUT : dq;
   sem_host i_sem_host (.CLK, .RSTN, .CE, .CMD_VALID, .CMD_OP, .CMD_FLAG, .CMD_READY,
      .RSP_VALID, .RSP_GRANTED, .RSP_FLAG_HIGH, .FLAG_SPACE_SELECT_N,
      .CHIP_ENABLE_LOW_ACTIVE_N(), .CHIP_ENABLE_HIGH_ACTIVE(), .WRITE_N, .OUTPUT_ENABLE_N,
      .BYTE_LANE_ENABLE_N, .ADDR, .DATA_OUT, .DATA_OE, .DATA_IN);
   sem_flag_model i_sem_flag_model (.sel_n(FLAG_SPACE_SELECT_N), .we_n(WRITE_N),
      .oe_n(OUTPUT_ENABLE_N), .be_n(BYTE_LANE_ENABLE_N), .idx(ADDR[2:0]),
      .wbit(DATA_OUT[0]), .dq(dq));
   always #5 CLK = ~CLK;
   always @(posedge CLK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", nm, e, s);
      end
   endtask
   // note bit 2 marks a response whose grant and flag level are checked
   always @(negedge CLK) if (RSP_VALID === 1'b1 && q.size() != 0) begin
      logic [2:0] e;
      e = q.pop_front();
      if (e[2]) chk("granted,flag_high", e[1:0], {RSP_GRANTED, RSP_FLAG_HIGH});
   end
   task automatic cmd(input logic [1:0] op, input logic [2:0] f, input logic [2:0] e);
      int n;
      n = 0;
      q.push_back(e);
      while (CMD_READY !== 1'b1 && n < 100) begin
         @(negedge CLK);
         n++;
      end
      CMD_VALID = 1'b1;
      CMD_OP = op;
      CMD_FLAG = f;
      @(negedge CLK);
      CMD_VALID = 1'b0;
      while (q.size() != 0 && n < 300) begin
         @(negedge CLK);
         n++;
      end
   endtask
   task automatic far(input logic [2:0] f, input logic v);
      i_sem_flag_model.far_write(f, v);
   endtask
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction
   initial begin
      repeat (4) @(negedge CLK);
      RSTN = 1'b1;
      cmd(sem_host_pkg::CMD_INIT, 3'h0, 3'b101);
      for (int i = 0; i < 8; i++) far(3'(i), 1'b1);
      $display("init test done");
      for (int i = 0; i < 8; i++) begin
         cmd(sem_host_pkg::CMD_CLAIM, 3'(i), 3'b110);
         chk("far flag", 2'b01, {1'b0, i_sem_flag_model.far_read(3'(i))});
         far(3'(i), 1'b0);
         cmd(sem_host_pkg::CMD_READ, 3'(i), 3'b110);
         cmd(sem_host_pkg::CMD_RELEASE, 3'(i), 3'b101);
         chk("far flag", 2'b00, {1'b0, i_sem_flag_model.far_read(3'(i))});
         cmd(sem_host_pkg::CMD_CLAIM, 3'(i), 3'b101);
         far(3'(i), 1'b1);
         cmd(sem_host_pkg::CMD_READ, 3'(i), 3'b110);
         cmd(sem_host_pkg::CMD_RELEASE, 3'(i), 3'b101);
      end
      $display("handover test done");
      for (int k = 0; k < 12; k++) begin
         seed = xorshift(seed);
         far(seed[2:0], seed[8]);
         cmd(sem_host_pkg::CMD_CLAIM, seed[2:0], seed[8] ? 3'b110 : 3'b101);
         cmd(sem_host_pkg::CMD_RELEASE, seed[2:0], 3'b101);
         far(seed[2:0], 1'b1);
      end
      $display("random contention test done");
      print_verdict();
   end
endmodule
bind sem_host sem_host_monitor i_sem_host_monitor (.CLK, .RSTN, .CMD_VALID, .CMD_READY,
   .RSP_VALID, .FLAG_SPACE_SELECT_N, .CHIP_ENABLE_LOW_ACTIVE_N, .CHIP_ENABLE_HIGH_ACTIVE,
   .WRITE_N, .OUTPUT_ENABLE_N, .BYTE_LANE_ENABLE_N,
   .ADDR, .DATA_OUT, .DATA_OE);
`default_nettype wire
